// ===== rtl/psar_defines.svh
// offsets, field positions and reset values of the phy status register bank
`ifndef PSAR_DEFINES_SVH
`define PSAR_DEFINES_SVH

// register indices; byte address is four times the index
`define PSAR_IDX_STATUS   4'h1
`define PSAR_IDX_ID_HIGH  4'h2
`define PSAR_IDX_ID_LOW   4'h3
`define PSAR_IDX_ADV      4'h4
`define PSAR_IDX_PARTNER  4'h5
`define PSAR_IDX_EXPAN    4'h6
`define PSAR_IDX_IRQ_STAT 4'h8
`define PSAR_IDX_IRQ_CLR  4'h9
`define PSAR_IDX_IRQ_EN   4'ha

// basic status fields
`define PSAR_ST_CONST     16'h79c9
`define PSAR_ST_AN_DONE   5
`define PSAR_ST_RFAULT    4
`define PSAR_ST_LINK      2
`define PSAR_ST_JABBER    1

// advertisement
`define PSAR_ADV_RST      16'h01e1
`define PSAR_ADV_WMASK    16'hafff

// partner ability
`define PSAR_PARTNER_MASK 16'hefff

// expansion fields
`define PSAR_EX_CONST     16'h0004
`define PSAR_EX_PDFAULT   4
`define PSAR_EX_PARTNER_NP 3
`define PSAR_EX_PAGE      1
`define PSAR_EX_PARTNER_AN 0

// interrupt event bits
`define PSAR_EV_N         6
`define PSAR_EV_RFAULT    0
`define PSAR_EV_JABBER    1
`define PSAR_EV_LINKDOWN  2
`define PSAR_EV_PAGE      3
`define PSAR_EV_PDFAULT   4
`define PSAR_EV_AN_DONE   5

`endif

// ===== rtl/psar_pkg.sv
// types shared by the phy status register bank
package psar_pkg;
	typedef enum logic [1:0] {
		PSAR_OKAY   = 2'h0,
		PSAR_SLVERR = 2'h2
	} psar_resp_t;
endpackage : psar_pkg

// ===== rtl/psar_regs.sv
// phy status and auto-negotiation register bank behind an axi4-lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "psar_defines.svh"

module psar_regs #(
	parameter int          ADDR_W   = 8,
	// identity values below are arbitrary
	parameter logic [15:0] OUI_HIGH = 16'h1234,
	parameter logic [5:0]  OUI_LOW  = 6'h15,
	parameter logic [5:0]  MODEL    = 6'h2a,
	parameter logic [3:0]  REVISION = 4'h3
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              remote_fault,
	input  wire logic              jabber,
	input  wire logic              link_up,
	input  wire logic              page_received,
	input  wire logic              parallel_fault,
	input  wire logic              an_complete,
	input  wire logic              link_partner_an_able,
	input  wire logic              link_partner_np_able,
	input  wire logic              link_partner_page_valid,
	input  wire logic [15:0]       link_partner_page,
	output logic [15:0]            adv_word,
	output logic                   irq
);

	function automatic logic psar_hit(input logic [ADDR_W-1:0] addr,
		input logic [3:0] idx);
		psar_hit = (addr[ADDR_W-1:2] == {{(ADDR_W-6){1'b0}}, idx});
	endfunction : psar_hit

	logic              awready_reg, wready_reg, bvalid_reg;
	logic              arready_reg, rvalid_reg, irq_reg;
	logic [1:0]        bresp_reg, rresp_reg;
	logic [31:0]       rdata_reg, wdata_reg;
	logic              aw_held_reg, w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [3:0]        wstrb_reg;
	logic [15:0]       adv_reg, adv_next, partner_reg;
	logic              rf_reg, jab_reg, link_reg, page_reg, pdf_reg;
	logic              an_done_reg, partner_an_reg, partner_np_reg;
	logic              rf_d_reg, jab_d_reg, link_up_d_reg;
	logic              page_d_reg, pdf_d_reg, an_d_reg;
	logic [`PSAR_EV_N-1:0] ista_reg, ien_reg, ev;
	logic              aw_take, w_take, ar_take, do_wr;
	logic              wr_adv, wr_clr, wr_en, wr_ok;
	logic              rd_status, rd_expan, rd_ok;
	logic [15:0]       rd_word, status_word, id_low_word, expan_word;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign adv_word      = adv_reg;
	assign irq           = irq_reg;

	assign aw_take = s_axi_awvalid & awready_reg;
	assign w_take  = s_axi_wvalid & wready_reg;
	assign ar_take = s_axi_arvalid & arready_reg;
	assign do_wr   = aw_held_reg & w_held_reg & ~bvalid_reg;

	// write decode; only adv, clear and enable take data
	assign wr_adv = do_wr & psar_hit(aw_addr_reg, `PSAR_IDX_ADV);
	assign wr_clr = do_wr & psar_hit(aw_addr_reg, `PSAR_IDX_IRQ_CLR);
	assign wr_en  = do_wr & psar_hit(aw_addr_reg, `PSAR_IDX_IRQ_EN);
	assign wr_ok  = psar_hit(aw_addr_reg, `PSAR_IDX_STATUS)
		| psar_hit(aw_addr_reg, `PSAR_IDX_ID_HIGH)
		| psar_hit(aw_addr_reg, `PSAR_IDX_ID_LOW)
		| psar_hit(aw_addr_reg, `PSAR_IDX_ADV)
		| psar_hit(aw_addr_reg, `PSAR_IDX_PARTNER)
		| psar_hit(aw_addr_reg, `PSAR_IDX_EXPAN)
		| psar_hit(aw_addr_reg, `PSAR_IDX_IRQ_STAT)
		| psar_hit(aw_addr_reg, `PSAR_IDX_IRQ_CLR)
		| psar_hit(aw_addr_reg, `PSAR_IDX_IRQ_EN);

	assign rd_status = ar_take & psar_hit(s_axi_araddr, `PSAR_IDX_STATUS);
	assign rd_expan  = ar_take & psar_hit(s_axi_araddr, `PSAR_IDX_EXPAN);

	// write address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (aw_take) begin
			awready_reg <= 1'b0;
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_held_reg <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg <= 1'b1;
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb_reg  <= '0;
		end else if (w_take) begin
			wready_reg <= 1'b0;
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb_reg  <= s_axi_wstrb;
		end else if (do_wr) begin
			w_held_reg <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= psar_pkg::PSAR_OKAY;
		end else if (do_wr) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? psar_pkg::PSAR_OKAY : psar_pkg::PSAR_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// advertisement: writable bits only, per byte lane
	always_comb begin
		adv_next = adv_reg;
		if (wstrb_reg[0]) begin
			adv_next[7:0] = wdata_reg[7:0];
		end
		if (wstrb_reg[1]) begin
			adv_next[15:8] = wdata_reg[15:8];
		end
		adv_next = adv_next & `PSAR_ADV_WMASK;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adv_reg <= `PSAR_ADV_RST;
		end else if (wr_adv) begin
			adv_reg <= adv_next;
		end
	end

	// partner base page, captured when valid with bit 12 cleared
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			partner_reg <= '0;
		end else if (link_partner_page_valid) begin
			partner_reg <= link_partner_page & `PSAR_PARTNER_MASK;
		end
	end

	// latched status; an event in the read cycle survives the read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rf_reg   <= 1'b0;
			jab_reg  <= 1'b0;
			link_reg <= 1'b0;
		end else begin
			rf_reg   <= remote_fault | (rf_reg & ~rd_status);
			jab_reg  <= jabber | (jab_reg & ~rd_status);
			link_reg <= link_up & (link_reg | rd_status);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_reg <= 1'b0;
			pdf_reg  <= 1'b0;
		end else begin
			page_reg <= page_received & (page_reg | rd_expan);
			pdf_reg  <= parallel_fault | (pdf_reg & ~rd_expan);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			an_done_reg    <= 1'b0;
			partner_an_reg <= 1'b0;
			partner_np_reg <= 1'b0;
		end else begin
			an_done_reg    <= an_complete;
			partner_an_reg <= link_partner_an_able;
			partner_np_reg <= link_partner_np_able;
		end
	end

	assign status_word = `PSAR_ST_CONST
		| ({15'h0000, an_done_reg} << `PSAR_ST_AN_DONE)
		| ({15'h0000, rf_reg} << `PSAR_ST_RFAULT)
		| ({15'h0000, link_reg} << `PSAR_ST_LINK)
		| ({15'h0000, jab_reg} << `PSAR_ST_JABBER);

	assign id_low_word = {OUI_LOW, MODEL, REVISION};

	assign expan_word = `PSAR_EX_CONST
		| ({15'h0000, pdf_reg} << `PSAR_EX_PDFAULT)
		| ({15'h0000, partner_np_reg} << `PSAR_EX_PARTNER_NP)
		| ({15'h0000, page_reg} << `PSAR_EX_PAGE)
		| ({15'h0000, partner_an_reg} << `PSAR_EX_PARTNER_AN);

	// read decode
	always_comb begin
		rd_word = 16'h0000;
		rd_ok   = 1'b1;
		unique case (ADDR_W'(s_axi_araddr[ADDR_W-1:2]))
			ADDR_W'(`PSAR_IDX_STATUS):   rd_word = status_word;
			ADDR_W'(`PSAR_IDX_ID_HIGH):  rd_word = OUI_HIGH;
			ADDR_W'(`PSAR_IDX_ID_LOW):   rd_word = id_low_word;
			ADDR_W'(`PSAR_IDX_ADV):      rd_word = adv_reg;
			ADDR_W'(`PSAR_IDX_PARTNER):  rd_word = partner_reg;
			ADDR_W'(`PSAR_IDX_EXPAN):    rd_word = expan_word;
			ADDR_W'(`PSAR_IDX_IRQ_STAT): rd_word = {10'h000, ista_reg};
			ADDR_W'(`PSAR_IDX_IRQ_CLR):  rd_word = 16'h0000;
			ADDR_W'(`PSAR_IDX_IRQ_EN):   rd_word = {10'h000, ien_reg};
			default:                     rd_ok   = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= psar_pkg::PSAR_OKAY;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= {16'h0000, rd_word};
			rresp_reg   <= rd_ok ? psar_pkg::PSAR_OKAY : psar_pkg::PSAR_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	// edge history for interrupt events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rf_d_reg      <= 1'b0;
			jab_d_reg     <= 1'b0;
			link_up_d_reg <= 1'b0;
			page_d_reg    <= 1'b0;
			pdf_d_reg     <= 1'b0;
			an_d_reg      <= 1'b0;
		end else begin
			rf_d_reg      <= remote_fault;
			jab_d_reg     <= jabber;
			link_up_d_reg <= link_up;
			page_d_reg    <= page_received;
			pdf_d_reg     <= parallel_fault;
			an_d_reg      <= an_complete;
		end
	end

	assign ev[`PSAR_EV_RFAULT]   = remote_fault & ~rf_d_reg;
	assign ev[`PSAR_EV_JABBER]   = jabber & ~jab_d_reg;
	assign ev[`PSAR_EV_LINKDOWN] = ~link_up & link_up_d_reg;
	assign ev[`PSAR_EV_PAGE]     = page_received & ~page_d_reg;
	assign ev[`PSAR_EV_PDFAULT]  = parallel_fault & ~pdf_d_reg;
	assign ev[`PSAR_EV_AN_DONE]  = an_complete & ~an_d_reg;

	// sticky interrupt status; a new event beats a clear
	for (genvar i = 0; i < `PSAR_EV_N; i++) begin : g_ista
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ista_reg[i] <= 1'b0;
			end else begin
				ista_reg[i] <= ev[i]
					| (ista_reg[i] & ~(wr_clr & wstrb_reg[0] & wdata_reg[i]));
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_reg <= '0;
		end else if (wr_en && wstrb_reg[0]) begin
			ien_reg <= wdata_reg[`PSAR_EV_N-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(ista_reg & ien_reg);
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_rd_status;
		ar_take && psar_hit(s_axi_araddr, `PSAR_IDX_STATUS);
	endsequence
	sequence s_rd_id;
		ar_take && psar_hit(s_axi_araddr, `PSAR_IDX_ID_LOW);
	endsequence
	a_status_consts: assert property (
		status_word[15:9] == 7'h3c)
		else $error("status capability bits wrong");
	a_ext_status: assert property (
		s_rd_status |=> s_axi_rvalid && s_axi_rdata[8])
		else $error("extended status bit not set");
	a_preamble_free: assert property (
		s_rd_status |=> s_axi_rdata[6] && s_axi_rdata[7])
		else $error("preamble suppression bit not set");
	a_fault_latch: assert property (
		remote_fault ##1 (!remote_fault && !rd_status) |=> rf_reg)
		else $error("remote fault not held");
	a_jabber_latch: assert property (
		jabber |=> jab_reg)
		else $error("jabber not latched");
	a_link_low: assert property (
		(!link_reg && !rd_status) |=> !link_reg)
		else $error("link low not held");
	a_cap_ones: assert property (
		s_rd_status |=> (s_axi_rdata[3:0] & 4'h9) == 4'h9)
		else $error("capability ones missing");
	a_id_word: assert property (
		s_rd_id |=> s_axi_rdata[15:0] == {OUI_LOW, MODEL, REVISION})
		else $error("identifier word wrong");
	a_adv_reset: assert property (
		$rose(aresetn) |-> adv_reg == `PSAR_ADV_RST)
		else $error("advertisement reset value wrong");
	a_adv_reserved: assert property (
		adv_reg[14] == 1'b0 && adv_reg[12] == 1'b0)
		else $error("advertisement reserved bit set");
	a_partner_capture: assert property (
		link_partner_page_valid |=>
			partner_reg == ($past(link_partner_page) & `PSAR_PARTNER_MASK))
		else $error("partner page not captured");
	a_pdf_latch: assert property (
		parallel_fault ##1 !rd_expan |=> pdf_reg)
		else $error("parallel fault not held");
	a_expan_fixed: assert property (
		expan_word[15:5] == 11'h000 && expan_word[2])
		else $error("expansion fixed bits wrong");
	a_an_done: assert property (
		an_complete ##1 an_complete |-> status_word[5])
		else $error("an complete not shown");
	a_ro_write: assert property (
		do_wr && !wr_adv |=> adv_reg == $past(adv_reg))
		else $error("advertisement changed by other write");

endmodule : psar_regs

// ===== dv/psar_mgmt_master.sv
// management controller model: axi4-lite master for register access
`timescale 1ns/100ps

module psar_mgmt_master (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// released payloads show the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : psar_mgmt_master

// ===== dv/psar_regs_tb_top.sv
// self-checking testbench of the phy status register bank
`timescale 1ns/100ps

module psar_regs_tb_top;
	logic        aclk, aresetn, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        remote_fault, jabber, link_up, page_received, parallel_fault;
	logic        an_complete, link_partner_an_able, link_partner_np_able;
	logic        link_partner_page_valid;
	logic [15:0] link_partner_page, adv_word;
	int          errors = 0;
	int          n_compared = 0;

	// identity values are arbitrary
	psar_regs #(.ADDR_W(8), .OUI_HIGH(16'hc3a5), .OUI_LOW(6'h0e),
		.MODEL(6'h31), .REVISION(4'h9)) DUT (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .remote_fault, .jabber, .link_up, .page_received,
		.parallel_fault, .an_complete, .link_partner_an_able,
		.link_partner_np_able, .link_partner_page_valid,
		.link_partner_page, .adv_word, .irq);

	psar_mgmt_master M (.aclk, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic summarize;
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		M.rd({2'b00, idx, 2'b00}, d, r);
		chk($sformatf("read %0h", idx), exp, d);
		chk($sformatf("rresp %0h", idx), 32'h0, {30'h0, r});
	endtask : rdc

	task automatic wrc(input logic [3:0] idx, input logic [31:0] d);
		logic [1:0] r;
		M.wr({2'b00, idx, 2'b00}, d, r);
		chk($sformatf("bresp %0h", idx), 32'h0, {30'h0, r});
	endtask : wrc

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rdc(4'h1, 32'h79c9);
		rdc(4'h2, 32'hc3a5);
		rdc(4'h3, 32'h3b19);
		rdc(4'h4, 32'h01e1);
		rdc(4'h5, 32'h0000);
		rdc(4'h6, 32'h0004);
		chk("adv_word", 32'h01e1, {16'h0, adv_word});
		M.rd(8'h1c, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped resp", 32'h2, {30'h0, r});
		M.wr(8'h1c, 32'h0000ffff, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
	endtask : t_reset

	task automatic t_adv;
		wrc(4'h4, 32'hffff);
		rdc(4'h4, 32'hafff);
		chk("adv_word", 32'hafff, {16'h0, adv_word});
		wrc(4'h4, 32'h0c00);
		rdc(4'h4, 32'h0c00);
		wrc(4'h4, 32'h01e1);
		wrc(4'h1, 32'hffff);
		rdc(4'h1, 32'h79c9);
		wrc(4'h3, 32'h0000);
		rdc(4'h3, 32'h3b19);
		wrc(4'h5, 32'hffff);
		rdc(4'h5, 32'h0000);
	endtask : t_adv

	task automatic t_latch_high;
		@(posedge aclk);
		remote_fault <= 1'b1;
		jabber <= 1'b1;
		parallel_fault <= 1'b1;
		@(posedge aclk);
		remote_fault <= 1'b0;
		jabber <= 1'b0;
		parallel_fault <= 1'b0;
		tick(2);
		rdc(4'h1, 32'h79db);
		rdc(4'h1, 32'h79c9);
		rdc(4'h6, 32'h0014);
		rdc(4'h6, 32'h0004);
	endtask : t_latch_high

	task automatic t_latch_low;
		@(posedge aclk);
		link_up <= 1'b1;
		page_received <= 1'b1;
		tick(2);
		rdc(4'h1, 32'h79c9);
		rdc(4'h1, 32'h79cd);
		rdc(4'h6, 32'h0004);
		rdc(4'h6, 32'h0006);
		@(posedge aclk);
		link_up <= 1'b0;
		page_received <= 1'b0;
		@(posedge aclk);
		link_up <= 1'b1;
		page_received <= 1'b1;
		tick(2);
		rdc(4'h1, 32'h79c9);
		rdc(4'h1, 32'h79cd);
		rdc(4'h6, 32'h0004);
		rdc(4'h6, 32'h0006);
	endtask : t_latch_low

	task automatic t_partner;
		@(posedge aclk);
		link_partner_page <= 16'hffff;
		link_partner_page_valid <= 1'b1;
		an_complete <= 1'b1;
		link_partner_an_able <= 1'b1;
		link_partner_np_able <= 1'b1;
		@(posedge aclk);
		link_partner_page_valid <= 1'b0;
		link_partner_page <= 16'h0000;
		tick(2);
		rdc(4'h5, 32'hefff);
		rdc(4'h6, 32'h000f);
		rdc(4'h1, 32'h79ed);
		rdc(4'h5, 32'hefff);
	endtask : t_partner

	task automatic t_irq;
		wrc(4'ha, 32'h3f);
		wrc(4'h9, 32'h3f);
		tick(2);
		chk("irq idle", 32'h0, {31'h0, irq});
		rdc(4'h8, 32'h00);
		@(posedge aclk);
		jabber <= 1'b1;
		@(posedge aclk);
		jabber <= 1'b0;
		tick(3);
		chk("irq set", 32'h1, {31'h0, irq});
		rdc(4'h8, 32'h02);
		rdc(4'ha, 32'h3f);
		wrc(4'h9, 32'h02);
		tick(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wrc(4'ha, 32'h00);
		@(posedge aclk);
		remote_fault <= 1'b1;
		@(posedge aclk);
		remote_fault <= 1'b0;
		tick(3);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdc(4'h8, 32'h01);
		rdc(4'h9, 32'h00);
	endtask : t_irq

	initial begin
		aresetn = 1'b0;
		{remote_fault, jabber, link_up, page_received} = 4'h0;
		{parallel_fault, an_complete, link_partner_an_able} = 3'h0;
		{link_partner_np_able, link_partner_page_valid} = 2'h0;
		link_partner_page = 16'h0000;
		tick(3);
		aresetn <= 1'b1;
		t_reset();
		t_adv();
		t_latch_high();
		t_latch_low();
		t_partner();
		t_irq();
		summarize();
	end

	initial begin
		tick(20000);
		errors++;
		summarize();
	end
endmodule : psar_regs_tb_top
